// ==== dsf_pkg.sv ====
// package for the dual symmetric fir datapath: config fields, widths, timing
// assumes a single 20 MHz pclk domain
package dsf_pkg;
    localparam int unsigned DATA_W = 10;
    localparam int unsigned COEF_W = 10;
    localparam int unsigned ALU_W = 11;
    localparam int unsigned PROD_W = 21;
    localparam int unsigned ACC_W = 26;
    localparam int unsigned OUT_W = 28;
    localparam int unsigned TAPS = 4;
    localparam int unsigned NSTAGE = 4;
    localparam int unsigned MAXLEN = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned FRAC_SHIFT = 10;
    localparam int unsigned APB_W = 32;
    // apb byte addresses
    localparam logic [11:0] ADDR_CFG0 = 12'h000;
    localparam logic [11:0] ADDR_CFG1 = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_COEF = 12'h00c;
    // control register 0 fields
    localparam int unsigned C0_DECIM_LSB = 0;
    localparam int unsigned C0_DUAL = 4;
    localparam int unsigned C0_ODDSYM = 5;
    localparam int unsigned C0_A_EVEN = 6;
    localparam int unsigned C0_B_EVEN = 7;
    localparam int unsigned C0_B_SRC = 8;
    localparam int unsigned C0_ILV = 9;
    // control register 1 fields
    localparam int unsigned C1_REV_DIS = 4;
    localparam int unsigned C1_RND_LSB = 5;
    localparam int unsigned C1_RND_DIS = 9;
    localparam logic [9:0] CFG0_RESET = 10'h010;
    localparam logic [9:0] CFG1_RESET = 10'h200;
    // internal reset after a control write
    localparam int unsigned IRST_CYC = 6;
    localparam logic [2:0] IRST_LOAD = 3'h6;
    // round position code 0 adds at weight 2^-10, i.e. output bit 0
    localparam logic [3:0] RND_MAX = 4'hb;

    typedef struct packed {
        logic [DATA_W-1:0] ina;
        logic [DATA_W-1:0] inb;
        logic block_transfer_strobe;
        logic forward_path_select_n;
        logic reverse_path_select_n;
        logic accumulate_enable;
        logic [1:0] output_combine_select;
        logic shift_enable_n;
    } dsf_ctl_type;

    typedef struct packed {
        logic [9:0] cfg0;
        logic [9:0] cfg1;
    } dsf_cfg_type;
endpackage : dsf_pkg

// ==== dsf_lifo_mem.sv ====
// small memory for the feedback section: two lifo halves plus delay line
// read data come out of a register; one write and one read port
module dsf_lifo_mem
    import dsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [PTR_W:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [PTR_W:0] raddr,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:2*MAXLEN-1];

    // storage write, no reset needed on contents
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : dsf_lifo_mem

// ==== dsf_fir_core.sv ====
// top of the dual symmetric fir datapath with its apb control registers
// assumes stream inputs are synchronous to pclk; apb master on same clock
// Functional notes
// RULE_01 - reversed block size equals spacing of transfer strobe falling edges
// RULE_02 - host keeps strobe period and phase fixed once block size is set
// RULE_03 - reversal disabled: forward data goes through feedback delay line
// RULE_04 - feedback delay line length equals programmed decimation length
// RULE_05 - single mode chains filters; second turns round, first always delays
// RULE_06 - even taps take third stage output, odd taps take its input; filter a at decimation 0 or 1 takes the output for odd taps too
// RULE_07 - decimation by n: host reads output once every n clocks
// RULE_08 - forward operand zero when forward select high
// RULE_09 - reverse operand zero when reverse select high
// RULE_10 - both selects low: reverse plus or minus forward by symmetry
// RULE_11 - reverse select high: pass forward, or negate it if odd symmetry
// RULE_12 - forward select high: pass reverse regardless of symmetry
// RULE_13 - two accumulators sum while enabled; output registers hold
// RULE_14 - enable low: zero feedback, load sums into output registers
// RULE_15 - combine code: a+b>>10, a+b, a only, b only
// RULE_16 - rounding adds one at weight chosen by round position field
// RULE_17 - loader stores odd-tap middle coefficient already halved
// RULE_18 - decimating even filter uses delay length equal to factor
// RULE_19 - software never picks odd taps with odd symmetry
// RULE_20 - interleaved streams need matching configuration chosen by software
// RULE_21 - four-tap asymmetric uses even taps and pass forward mode
// RULE_22 - eight-tap asymmetric clocks twice, reverse then forward path
// RULE_23 - lifos swap roles only on strobe high to low edge
// RULE_24 - shift enable high holds input and delay registers
// RULE_25 - control write causes six-cycle internal reset, coefficients kept
//
// The APB slave port and the address map were left to the implementer.
module dsf_fir_core
    import dsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [APB_W-1:0] pwdata,
    output logic [APB_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dsf_ctl_type ctl,
    input wire logic [COEF_W*TAPS-1:0] coef_a,
    input wire logic [COEF_W*TAPS-1:0] coef_b,
    output logic [OUT_W-1:0] result
);
    typedef logic signed [DATA_W-1:0] dsf_smp_type;
    typedef struct packed {
        dsf_cfg_type cfg;
        logic [2:0] irst;
        logic [APB_W-1:0] rdata;
        logic strobe_d;
        logic bank;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] blen;
        logic [PTR_W-1:0] bcnt;
        logic [PTR_W-1:0] dptr;
        dsf_smp_type [1:0][NSTAGE-1:0][MAXLEN-1:0] fwd;
        dsf_smp_type [1:0][NSTAGE-1:0][MAXLEN-1:0] rev;
        logic signed [ACC_W-1:0] acc_a;
        logic signed [ACC_W-1:0] acc_b;
        logic signed [ACC_W-1:0] hold_a;
        logic signed [ACC_W-1:0] hold_b;
        logic [OUT_W-1:0] result;
    } dsf_state_type;

    dsf_state_type st, next_st;
    logic [DATA_W-1:0] mem_rdata;
    logic mem_we;
    logic [PTR_W:0] mem_waddr, mem_raddr;
    logic [PTR_W-1:0] dlen;
    logic in_reset;

    // pre-adder: sign-extended forward and reverse operands per select and symmetry
    function automatic logic signed [ALU_W-1:0] alu_op(
        input dsf_smp_type f,
        input dsf_smp_type r,
        input logic fsel_n,
        input logic rsel_n,
        input logic odd_sym
    );
        logic signed [ALU_W-1:0] a;
        logic signed [ALU_W-1:0] b;
        a = fsel_n ? '0 : ALU_W'(f); // RULE_08
        b = rsel_n ? '0 : ALU_W'(r); // RULE_09
        if (!fsel_n && rsel_n) begin
            alu_op = odd_sym ? -a : a; // RULE_11
        end else if (fsel_n) begin
            alu_op = b; // RULE_12
        end else begin
            alu_op = odd_sym ? b - a : b + a; // RULE_10
        end
    endfunction : alu_op

    // sum of four pre-added taps times coefficients
    function automatic logic signed [ACC_W-1:0] tap_sum(
        input logic signed [TAPS*ALU_W-1:0] pre,
        input logic [COEF_W*TAPS-1:0] coef
    );
        logic signed [ACC_W-1:0] s;
        s = '0;
        for (int i = 0; i < TAPS; i++) begin
            s = s + ACC_W'($signed(pre[i*ALU_W +: ALU_W])
                * $signed(coef[i*COEF_W +: COEF_W]));
        end
        tap_sum = s;
    endfunction : tap_sum

    logic [DATA_W-1:0] mem_wdata_w;
    logic signed [TAPS*ALU_W-1:0] pre_a, pre_b;

    // feedback memory: two lifo halves for reversal, delay line in pass mode
    dsf_lifo_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata_w),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // decimation length, 0 and 1 mean no extra delay
    assign dlen = (st.cfg.cfg0[C0_DECIM_LSB +: 4] < 4'h2) ? 4'h1
        : st.cfg.cfg0[C0_DECIM_LSB +: 4]; // RULE_18 RULE_07
    assign in_reset = (st.irst != 3'h0);

    // feedback tap point for filter b, pointer and address steering
    always_comb begin
        logic a_even;
        logic b_even;
        logic rev_dis;
        logic dual;
        dsf_smp_type tap_b;
        a_even = st.cfg.cfg0[C0_A_EVEN];
        b_even = st.cfg.cfg0[C0_B_EVEN];
        rev_dis = st.cfg.cfg1[C1_REV_DIS];
        dual = st.cfg.cfg0[C0_DUAL];
        // third stage output or the value it will present next clock
        tap_b = b_even ? st.fwd[1][2][dlen-4'h1]
            : ((dlen == 4'h1) ? st.fwd[1][1][0]
            : st.fwd[1][2][dlen-4'h2]); // RULE_06
        if (!dual) begin
            tap_b = b_even ? st.fwd[1][2][dlen-4'h1] : tap_b; // RULE_05
        end
        mem_wdata_w = tap_b;
        mem_we = !ctl.shift_enable_n && !in_reset; // RULE_24
        if (rev_dis) begin
            // circular delay line in upper half, same length as stages
            mem_waddr = {1'b1, st.dptr}; // RULE_03 RULE_04
            mem_raddr = {1'b1, (st.dptr == dlen - 4'h1) ? 4'h0
                : st.dptr + 4'h1};
        end else begin
            // write one half upward, read the other half downward
            mem_waddr = {st.bank, st.wptr}; // RULE_01
            mem_raddr = {!st.bank, (st.bcnt > st.wptr) ? st.bcnt - st.wptr
                - 4'h1 : 4'h0};
        end
    end

    // pre-adders for both filters
    genvar g;
    generate
        for (g = 0; g < TAPS; g++) begin : g_pre
            assign pre_a[g*ALU_W +: ALU_W] = alu_op(st.fwd[0][g][dlen-4'h1],
                st.rev[0][g][dlen-4'h1], ctl.forward_path_select_n,
                ctl.reverse_path_select_n, st.cfg.cfg0[C0_ODDSYM]);
            assign pre_b[g*ALU_W +: ALU_W] = alu_op(st.fwd[1][g][dlen-4'h1],
                st.rev[1][g][dlen-4'h1], ctl.forward_path_select_n,
                ctl.reverse_path_select_n, st.cfg.cfg0[C0_ODDSYM]);
        end
    endgenerate

    // next-state logic: bus, internal reset, delay lines, accumulators
    always_comb begin
        logic wr_acc;
        logic signed [ACC_W-1:0] sum_a;
        logic signed [ACC_W-1:0] sum_b;
        logic signed [OUT_W-1:0] comb;
        logic fall;
        dsf_smp_type in_b;
        dsf_smp_type fb_a;
        next_st = st;
        comb = '0;
        sum_a = '0;
        sum_b = '0;
        in_b = '0;
        fb_a = '0;
        wr_acc = psel && penable && pwrite;
        fall = st.strobe_d && !ctl.block_transfer_strobe;
        // apb access: zero wait state, registered read data
        next_st.rdata = '0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_CFG0: next_st.rdata = APB_W'(st.cfg.cfg0);
                ADDR_CFG1: next_st.rdata = APB_W'(st.cfg.cfg1);
                ADDR_STATUS: next_st.rdata = {27'h0, st.bank, in_reset,
                    st.irst};
                default: next_st.rdata = '0;
            endcase
        end
        if (wr_acc && paddr == ADDR_CFG0) begin
            next_st.cfg.cfg0 = pwdata[9:0];
            next_st.irst = IRST_LOAD; // RULE_25
        end else if (wr_acc && paddr == ADDR_CFG1) begin
            next_st.cfg.cfg1 = pwdata[9:0];
            next_st.irst = IRST_LOAD; // RULE_25
        end else if (in_reset) begin
            next_st.irst = st.irst - 3'h1;
        end
        next_st.strobe_d = ctl.block_transfer_strobe;
        in_b = st.cfg.cfg0[C0_B_SRC] ? ctl.inb : ctl.ina;
        // filter a feedback always a plain delay: third stage output, or for odd taps above decimation 1 the value it presents next clock
        fb_a = st.cfg.cfg0[C0_A_EVEN] ? st.fwd[0][2][dlen-4'h1]
            : st.fwd[0][2][(dlen == 4'h1) ? 4'h0 : dlen-4'h2]; // RULE_05
        if (in_reset) begin
            // coefficients live outside and stay untouched
            next_st.fwd = '0; // RULE_25
            next_st.rev = '0;
            next_st.acc_a = '0;
            next_st.acc_b = '0;
            next_st.hold_a = '0;
            next_st.hold_b = '0;
            next_st.wptr = '0;
            next_st.bcnt = '0;
            next_st.blen = '0;
            next_st.dptr = '0;
            next_st.bank = 1'b0;
        end else if (!ctl.shift_enable_n) begin // RULE_24
            for (int f = 0; f < 2; f++) begin
                for (int s = 0; s < NSTAGE; s++) begin
                    for (int k = MAXLEN-1; k > 0; k--) begin
                        next_st.fwd[f][s][k] = st.fwd[f][s][k-1];
                        next_st.rev[f][s][k] = st.rev[f][s][k-1];
                    end
                    next_st.fwd[f][s][0] = (s == 0) ? ((f == 0) ? ctl.ina
                        : (st.cfg.cfg0[C0_DUAL] ? in_b
                        : st.fwd[0][NSTAGE-1][dlen-4'h1]))
                        : st.fwd[f][s-1][dlen-4'h1];
                    next_st.rev[f][s][0] = (s == NSTAGE-1) ? ((f == 1)
                        ? mem_rdata : (st.cfg.cfg0[C0_DUAL] ? fb_a
                        : st.rev[1][0][dlen-4'h1]))
                        : st.rev[f][s+1][dlen-4'h1];
                end
            end
            next_st.dptr = (st.dptr == dlen - 4'h1) ? 4'h0
                : st.dptr + 4'h1; // RULE_04
            if (fall) begin
                // swap halves; block size is the strobe spacing
                next_st.bank = !st.bank; // RULE_23
                next_st.blen = st.wptr + 4'h1; // RULE_01
                next_st.bcnt = st.wptr + 4'h1;
                next_st.wptr = '0;
            end else begin
                next_st.wptr = st.wptr + 4'h1;
            end
        end
        // accumulators
        sum_a = tap_sum(pre_a, coef_a);
        sum_b = tap_sum(pre_b, coef_b);
        if (!in_reset) begin
            if (ctl.accumulate_enable) begin
                next_st.acc_a = st.acc_a + sum_a; // RULE_13
                next_st.acc_b = st.acc_b + sum_b;
            end else begin
                next_st.acc_a = sum_a; // RULE_14
                next_st.acc_b = sum_b;
                next_st.hold_a = st.acc_a; // RULE_14
                next_st.hold_b = st.acc_b;
            end
        end
        // output combine and rounding
        unique case (ctl.output_combine_select)
            2'b00: comb = OUT_W'(st.hold_a)
                + (OUT_W'(st.hold_b) >>> FRAC_SHIFT); // RULE_15
            2'b01: comb = OUT_W'(st.hold_a) + OUT_W'(st.hold_b);
            2'b10: comb = OUT_W'(st.hold_a);
            2'b11: comb = OUT_W'(st.hold_b);
        endcase
        if (!st.cfg.cfg1[C1_RND_DIS] &&
            st.cfg.cfg1[C1_RND_LSB +: 4] <= RND_MAX) begin
            comb = comb + (OUT_W'(1) << st.cfg.cfg1[C1_RND_LSB +: 4]); // RULE_16
        end
        next_st.result = comb;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cfg.cfg0 <= CFG0_RESET;
            st.cfg.cfg1 <= CFG1_RESET;
        end else begin
            st <= next_st;
        end
    end

    // prdata and result straight from flops; pready and pslverr tied to constants
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign result = st.result;
endmodule : dsf_fir_core

// ==== dsf_fir_checker.sv ====
// assertion checker for the dual symmetric fir datapath top ports
// assumes one pclk domain and apb writes taken in the access phase
module dsf_fir_checker
    import dsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [APB_W-1:0] pwdata,
    input wire logic [APB_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire dsf_ctl_type ctl,
    input wire logic [COEF_W*TAPS-1:0] coef_a,
    input wire logic [COEF_W*TAPS-1:0] coef_b,
    input wire logic [OUT_W-1:0] result
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] cfg1_q;
    logic [6:0] ctl_q;
    logic [79:0] coef_q;
    logic [3:0] n_hold, n_acc, n_zero;
    logic steady;
    logic [OUT_W-1:0] rnd_val;
    // controls and coefficients unchanged, no bus traffic
    assign steady = ctl[6:0] == ctl_q && {coef_a, coef_b} == coef_q && !psel;
    assign rnd_val = (cfg1_q[8:5] > RND_MAX) ? '0 : 28'h1 << cfg1_q[8:5];
    // run counters of steady cycles, saturating at 15
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg1_q <= CFG1_RESET;
            ctl_q <= '0;
            coef_q <= '0;
            n_hold <= '0;
            n_acc <= '0;
            n_zero <= '0;
        end else begin
            if (psel && penable && pwrite && paddr == ADDR_CFG1) begin
                cfg1_q <= pwdata[9:0];
            end
            ctl_q <= ctl[6:0];
            coef_q <= {coef_a, coef_b};
            n_hold <= !(steady && ctl.shift_enable_n) ? 4'h0
                : n_hold + {3'h0, n_hold != 4'hf};
            n_acc <= !(steady && ctl.accumulate_enable) ? 4'h0
                : n_acc + {3'h0, n_acc != 4'hf};
            n_zero <= !(steady && ctl.forward_path_select_n
                && ctl.reverse_path_select_n && !ctl.accumulate_enable)
                ? 4'h0 : n_zero + {3'h0, n_zero != 4'hf};
        end
    end
    a_ready_high: assert property (pready) else $error("pready low");
    a_no_error: assert property (!pslverr) else $error("pslverr high");
    a_unmapped_zero: assert property (psel && !penable && !pwrite
        && paddr == 12'h010 |=> prdata == '0) else $error("hole read");
    a_write_clears: assert property (psel && penable && pwrite &&
        (paddr == ADDR_CFG0 || paddr == ADDR_CFG1) |-> ##[1:7]
        result == (cfg1_q[C1_RND_DIS] ? '0 : rnd_val))
        else $error("no clear after control write");
    a_zero_operands: assert property (n_zero == 4'hf &&
        cfg1_q[C1_RND_DIS] |-> result == '0) else $error("operands not zero");
    a_round_add: assert property (n_zero == 4'hf &&
        !cfg1_q[C1_RND_DIS] |-> result == rnd_val) else $error("bad round");
    a_shift_hold: assert property (n_hold == 4'hf |-> $stable(result))
        else $error("result moved while shift held");
    a_acc_hold: assert property (n_acc == 4'hf |-> $stable(result))
        else $error("result moved while accumulating");
endmodule : dsf_fir_checker

bind dsf_fir_core dsf_fir_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctl, .coef_a,
    .coef_b, .result);

// ==== dsf_host_model.sv ====
// host model streaming samples and the block transfer strobe
// assumes the bench hands it the wanted controls each cycle
module dsf_host_model
    import dsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rev_on,
    input wire dsf_ctl_type req,
    output dsf_ctl_type ctl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] phase;
    dsf_ctl_type nxt;
    // wanted controls with the strobe rhythm folded in
    always_comb begin
        nxt = req;
        nxt.block_transfer_strobe = rev_on && phase != 3'h7;
    end
    // fixed eight-cycle strobe rhythm, held low when reversal is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 3'h0;
            ctl <= '0;
        end else begin
            phase <= phase + 3'h1;
            ctl <= nxt;
        end
    end
endmodule : dsf_host_model

// ==== tb_dual_symmetric_fir_datapath.sv ====
// testbench for the dual symmetric fir datapath: apb setup and streams
// assumes a zero-wait apb slave and steady state after constant input
module tb_dual_symmetric_fir_datapath
    import dsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {string what; logic [31:0] v; logic [31:0] m;} dsf_note_type;
    dsf_note_type notes[$];
    dsf_note_type cur;
    logic pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seen;
    logic pready, pslverr, rev_on = 0;
    dsf_ctl_type req = '0, ctl;
    logic [39:0] coef_a = '0, coef_b = '0, ca, cb;
    logic [27:0] result;
    logic [1:0] look = 0;
    logic [9:0] x, y;
    int miscompares = 0, checked = 0;
    dsf_fir_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ctl, .coef_a, .coef_b, .result);
    dsf_host_model host (.pclk, .presetn, .rev_on, .req, .ctl);
    // free running clock
    initial begin
        forever #25 pclk = ~pclk;
    end
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic note(input logic [1:0] k, input string w,
            input logic [31:0] v, input logic [31:0] m);
        notes.push_back('{w, v & m, m});
        look <= k;
        @(posedge pclk);
        look <= 2'd0;
        @(posedge pclk);
    endtask : note
    task automatic drive(input logic [9:0] a, b, input logic f, r, ac,
            input logic [1:0] m, input logic h);
        req <= '{a, b, 1'b0, f, r, ac, m, h};
    endtask : drive
    function automatic logic signed [31:0] sum4(input logic [39:0] c);
        logic signed [31:0] s;
        s = 0;
        for (int i = 0; i < 4; i++) s += $signed(c[10*i +: 10]);
        return s;
    endfunction : sum4
    // steady-state output for constant samples on both inputs
    function automatic logic signed [31:0] filt(input logic f, r, o,
            input logic [1:0] m);
        logic signed [31:0] ea, eb;
        ea = ($signed(r ? 10'h0 : x) + (o ? -1 : 1) * $signed(f ? 10'h0 : x))
            * sum4(ca);
        eb = ($signed(r ? 10'h0 : y) + (o ? -1 : 1) * $signed(f ? 10'h0 : y))
            * sum4(cb);
        return m == 0 ? ea + (eb >>> 10) : m == 1 ? ea + eb : m == 2 ? ea : eb;
    endfunction : filt
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // compare the oldest note against the observed value
    always @(posedge pclk) begin
        if (look != 2'd0 && notes.size() > 0) begin
            cur = notes.pop_front();
            seen = (look == 2'd1) ? {{4{result[27]}}, result} : rd;
            checked++;
            if ((seen & cur.m) !== cur.v) begin
                miscompares++;
                $display("unexpected %s: expected %h, seen %h", cur.what,
                    cur.v, seen & cur.m);
            end
        end
    end
    // watchdog against a hung run
    initial begin
        repeat (6000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'haef1));
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(ADDR_CFG0, 1'b0, '0);
        note(2'd2, "cfg0 reset", 32'h010, 32'h3ff);
        apb(ADDR_CFG1, 1'b0, '0);
        note(2'd2, "cfg1 reset", 32'h200, 32'h3ff);
        apb(12'h010, 1'b1, '1);
        apb(12'h010, 1'b0, '0);
        note(2'd2, "hole", 32'h0, '1);
        apb(ADDR_CFG0, 1'b1, 32'h1d4);
        apb(ADDR_STATUS, 1'b0, '0);
        note(2'd2, "in reset", 32'h8, 32'h8);
        repeat (10) @(posedge pclk);
        apb(ADDR_STATUS, 1'b0, '0);
        note(2'd2, "reset over", 32'h0, 32'h8);
        apb(ADDR_CFG0, 1'b0, '0);
        note(2'd2, "cfg0", 32'h1d4, 32'h3ff);
        // every select pair, symmetry and combine code
        for (int i = 0; i < 12; i++) begin
            x = 10'($urandom);
            y = 10'($urandom);
            ca = 40'({$urandom, $urandom});
            cb = 40'({$urandom, $urandom});
            coef_a <= ca;
            coef_b <= cb;
            rev_on <= i >= 6;
            apb(ADDR_CFG0, 1'b1, 32'h1d0 | (i[2] ? 32'h20 : 32'h0)
                | (i >= 8 ? 32'h4 : 32'h0));
            apb(ADDR_CFG1, 1'b1, i >= 6 ? 32'h200 : 32'h210);
            drive(x, y, i[0], i[1], 1'b0, 2'(i + i / 4), 1'b0);
            repeat (80) @(posedge pclk);
            note(2'd1, "filtered", filt(i[0], i[1], i[2], 2'(i + i / 4)),
                '1);
        end
        rev_on <= 1'b0;
        apb(ADDR_CFG0, 1'b1, 32'h1d0);
        apb(ADDR_CFG1, 1'b1, 32'h210);
        drive(x, y, 1'b0, 1'b1, 1'b0, 2'd2, 1'b0);
        repeat (80) @(posedge pclk);
        note(2'd1, "pass forward", filt(0, 1, 0, 2), '1);
        drive(~x, y, 1'b0, 1'b1, 1'b0, 2'd2, 1'b1);
        repeat (24) @(posedge pclk);
        note(2'd1, "shift held", filt(0, 1, 0, 2), '1);
        drive(~x, y, 1'b0, 1'b1, 1'b1, 2'd2, 1'b0);
        repeat (24) @(posedge pclk);
        note(2'd1, "accumulating", filt(0, 1, 0, 2), '1);
        drive(~x, y, 1'b0, 1'b1, 1'b0, 2'd2, 1'b0);
        x = ~x;
        repeat (80) @(posedge pclk);
        note(2'd1, "reloaded", filt(0, 1, 0, 2), '1);
        drive(x, y, 1'b1, 1'b1, 1'b0, 2'd1, 1'b0);
        repeat (20) @(posedge pclk);
        // round positions, the top code 11 and code 15 beyond it
        for (int i = 0; i < 5; i++) begin
            apb(ADDR_CFG1, 1'b1, 32'h010 | ({28'h0, 4'(i * 4 - i / 3)} << 5));
            repeat (40) @(posedge pclk);
            note(2'd1, "rounded", i == 4 ? 32'h0
                : 32'h1 << (i * 4 - i / 3), '1);
        end
        report_and_stop();
    end
endmodule : tb_dual_symmetric_fir_datapath
